// >>> rtl/ierx_top.sv
// interrupt enable register, interrupt pin and contactless error flags
// all event strobes come from logic on ref_clk; register port is
// a simple synchronous read and write strobe interface
//
// Contract
// - bit 7 chooses push-pull or open-drain pin
// - bit 6 passes global flag to pin
// - bit 5 gates card detect request
// - bits 4..0 gate timer requests
// - eeprom command error sets eeprom flag
// - fifo write in busy states sets flag
// - write error clears on command or store
// - full fifo write sets overflow, ignores writes
// - under four data bits sets short flag
// - short or emd frames discarded, decoder stays
// - receive flags clear at receive start
// - transmit with empty fifo sets flag
// - collision sets flag, records first position
// - end-of-frame collision does not set flag
// - protocol fault sets flag, stops reception
// - protocol fault drops last received byte
// - parity or crc fault sets integrity flag
// - collision also sets integrity when selected
// - error request when listed flags become set
// - global flag from any enabled request
`timescale 1ns/1ps
`default_nettype none

module ierx_top
	import ierx_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic card_detect_request,
	input wire logic [4:0] timer_request,
	input wire logic other_enabled_request,
	output logic global_interrupt_flag,
	input wire logic irq_pin_in,
	output logic irq_pin_out,
	output logic irq_pin_oe,
	output logic error_interrupt_request,
	output logic [7:0] error_flags,
	input wire logic eeprom_cmd_start,
	input wire logic eeprom_cmd_error,
	input wire logic cl_command_start,
	input wire logic multi_frame_receive,
	input wire logic error_flags_stored,
	input wire logic [2:0] comm_state,
	input wire logic transceive_active,
	input wire logic receive_start,
	input wire logic crc_tx_active,
	input wire logic auth_active,
	input wire logic fifo_write,
	input wire logic fifo_full,
	input wire logic fifo_flush,
	output logic fifo_write_accept,
	input wire logic tx_required,
	input wire logic fifo_empty,
	input wire logic sof_valid,
	input wire logic data_bit,
	input wire logic frame_end,
	input wire logic emd_suppress,
	output logic receive_end_interrupt,
	output logic frame_discard,
	output logic receive_decoder_enable,
	input wire logic collision_event,
	input wire logic collision_in_eof,
	input wire logic [6:0] collision_pos,
	input wire logic collision_as_integrity_control,
	output logic [7:0] collision_position_register,
	input wire logic stop_bit_error,
	input wire logic sof_error,
	input wire logic byte_count_error,
	input wire logic parity_error,
	input wire logic crc_error,
	input wire logic rx_byte_write,
	output logic rx_byte_write_out
);

	logic [7:0] irq_en_reg;
	logic [7:0] irq_en_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic global_reg;
	logic global_next;
	logic pin_out_reg;
	logic pin_out_next;
	logic pin_oe_reg;
	logic pin_oe_next;
	logic err_irq_reg;
	logic err_irq_next;
	logic fifo_accept_reg;
	logic fifo_accept_next;
	logic byte_wr_reg;
	logic byte_wr_next;
	logic decoder_en_reg;
	logic decoder_en_next;
	logic [7:0] coll_pos_reg;
	logic [7:0] coll_pos_next;
	logic [2:0] comm_prev_reg;
	logic [2:0] comm_prev_next;

	logic [7:0] err_set;
	logic [7:0] err_clr;
	logic [7:0] err_q;
	logic short_event;
	logic accept_event;
	logic discard_event;
	logic rx_clear;
	logic rx_busy;
	logic prot_event;
	logic coll_valid_event;
	logic [5:0] masked_req;
	logic pin_asserted;

	// ==========================================================
	// frame length judgement
	ierx_frame_check u_frame_check
	(
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.sof_valid(sof_valid),
		.data_bit(data_bit),
		.frame_end(frame_end),
		.emd_suppress(emd_suppress),
		.short_frame(short_event),
		.frame_discard(discard_event),
		.frame_accept(accept_event)
	);

	// ==========================================================
	// error flags
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++)
		begin : g_err
			ierx_sticky_flag
			#(
				.RESET_VALUE(ERR_RESET[gi])
			)
			u_flag
			(
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.set(err_set[gi]),
				.clear(err_clr[gi]),
				.flag(err_q[gi])
			);
		end
	endgenerate

	always_comb
	begin
		rx_busy = (comm_state == COMM_RX_WAIT) ||
			(comm_state == COMM_WAIT_DATA) ||
			(comm_state == COMM_RECEIVING);
		rx_clear = receive_start || (transceive_active &&
			comm_state == COMM_WAIT_DATA &&
			comm_prev_reg != COMM_WAIT_DATA);
		prot_event = stop_bit_error || sof_error || byte_count_error;
		coll_valid_event = collision_event && !collision_in_eof;
		err_set = '0;
		err_clr = '0;
		err_set[ERR_EEPROM_BIT] = eeprom_cmd_error;
		err_clr[ERR_EEPROM_BIT] = eeprom_cmd_start;
		err_set[ERR_FIFO_WR_BIT] = fifo_write &&
			(crc_tx_active || rx_busy || auth_active);
		err_clr[ERR_FIFO_WR_BIT] = multi_frame_receive ?
			error_flags_stored : cl_command_start;
		err_set[ERR_OVERFLOW_BIT] = fifo_write && fifo_full;
		err_clr[ERR_OVERFLOW_BIT] = fifo_flush;
		err_set[ERR_SHORT_BIT] = short_event;
		err_clr[ERR_SHORT_BIT] = rx_clear;
		err_set[ERR_EMPTY_TX_BIT] = tx_required && fifo_empty;
		err_clr[ERR_EMPTY_TX_BIT] = cl_command_start;
		err_set[ERR_COLL_BIT] = coll_valid_event;
		err_clr[ERR_COLL_BIT] = rx_clear;
		err_set[ERR_PROT_BIT] = prot_event;
		err_clr[ERR_PROT_BIT] = rx_clear;
		err_set[ERR_INTEG_BIT] = parity_error || crc_error ||
			(coll_valid_event && collision_as_integrity_control);
		err_clr[ERR_INTEG_BIT] = rx_clear;
	end

	// ==========================================================
	// enable register, interrupt path, fifo and receive control
	always_comb
	begin
		irq_en_next = irq_en_reg;
		rdata_next = rdata_reg;
		coll_pos_next = coll_pos_reg;
		decoder_en_next = decoder_en_reg;
		if (reg_wr && reg_addr == IRQ_EN_OFFSET)
		begin
			irq_en_next = reg_wdata;
		end
		// reads only select data, flags stay as they are
		if (reg_rd)
		begin
			if (reg_addr == IRQ_EN_OFFSET)
			begin
				rdata_next = irq_en_reg;
			end
			else if (reg_addr == ERR_OFFSET)
			begin
				rdata_next = err_q;
			end
			else
			begin
				rdata_next = UNMAPPED_RDATA;
			end
		end
		masked_req = {card_detect_request, timer_request} &
			irq_en_reg[EN_CARD_BIT:EN_TIMER_LSB];
		global_next = (|masked_req) || other_enabled_request;
		pin_asserted = global_reg && irq_en_reg[EN_PIN_BIT];
		if (irq_en_reg[EN_DRIVE_BIT])
		begin
			pin_oe_next = 1'b1;
			pin_out_next = pin_asserted;
		end
		else
		begin
			pin_oe_next = pin_asserted;
			pin_out_next = 1'b0;
		end
		err_irq_next = |(err_set & ~err_q & ERR_IRQ_MASK);
		fifo_accept_next = fifo_write && !fifo_full &&
			!err_q[ERR_OVERFLOW_BIT];
		byte_wr_next = rx_byte_write && !prot_event &&
			!err_q[ERR_PROT_BIT];
		if (prot_event)
		begin
			decoder_en_next = 1'b0;
		end
		else if (receive_start || rx_clear)
		begin
			decoder_en_next = 1'b1;
		end
		if (rx_clear)
		begin
			coll_pos_next = {1'b0, COLL_POS_RESET};
		end
		if (coll_valid_event && !err_q[ERR_COLL_BIT])
		begin
			coll_pos_next = {1'b1, collision_pos};
		end
		comm_prev_next = comm_state;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			irq_en_reg <= IRQ_EN_RESET;
			rdata_reg <= RDATA_RESET;
			global_reg <= 1'b0;
			pin_out_reg <= 1'b0;
			pin_oe_reg <= 1'b0;
			err_irq_reg <= 1'b0;
			fifo_accept_reg <= 1'b0;
			byte_wr_reg <= 1'b0;
			decoder_en_reg <= 1'b0;
			coll_pos_reg <= {1'b0, COLL_POS_RESET};
			comm_prev_reg <= COMM_RESET;
		end
		else
		begin
			irq_en_reg <= irq_en_next;
			rdata_reg <= rdata_next;
			global_reg <= global_next;
			pin_out_reg <= pin_out_next;
			pin_oe_reg <= pin_oe_next;
			err_irq_reg <= err_irq_next;
			fifo_accept_reg <= fifo_accept_next;
			byte_wr_reg <= byte_wr_next;
			decoder_en_reg <= decoder_en_next;
			coll_pos_reg <= coll_pos_next;
			comm_prev_reg <= comm_prev_next;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata = rdata_reg;
	assign global_interrupt_flag = global_reg;
	assign irq_pin_out = pin_out_reg;
	assign irq_pin_oe = pin_oe_reg;
	assign error_interrupt_request = err_irq_reg;
	assign error_flags = err_q;
	assign fifo_write_accept = fifo_accept_reg;
	assign receive_end_interrupt = accept_event;
	assign frame_discard = discard_event;
	assign receive_decoder_enable = decoder_en_reg;
	assign collision_position_register = coll_pos_reg;
	assign rx_byte_write_out = byte_wr_reg;

	// pin readback is not needed by this block
	logic unused_pin_in;
	assign unused_pin_in = irq_pin_in;

endmodule : ierx_top

`default_nettype wire

// >>> rtl/ierx_pkg.sv
// constants for the interrupt enable and contactless error flag block
// shared by the top module and its leaf modules
`default_nettype none

package ierx_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] IRQ_EN_OFFSET = 8'h09;
	localparam logic [7:0] ERR_OFFSET = 8'h0A;
	localparam logic [7:0] IRQ_EN_RESET = 8'h00;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic [7:0] UNMAPPED_RDATA = 8'h00;

	// ==========================================================
	// enable register fields
	localparam int EN_DRIVE_BIT = 7;
	localparam int EN_PIN_BIT = 6;
	localparam int EN_CARD_BIT = 5;
	localparam int EN_TIMER_MSB = 4;
	localparam int EN_TIMER_LSB = 0;

	// ==========================================================
	// error register fields
	localparam int ERR_EEPROM_BIT = 7;
	localparam int ERR_FIFO_WR_BIT = 6;
	localparam int ERR_OVERFLOW_BIT = 5;
	localparam int ERR_SHORT_BIT = 4;
	localparam int ERR_EMPTY_TX_BIT = 3;
	localparam int ERR_COLL_BIT = 2;
	localparam int ERR_PROT_BIT = 1;
	localparam int ERR_INTEG_BIT = 0;
	localparam logic [7:0] ERR_IRQ_MASK = 8'h6B;

	// ==========================================================
	// transceiver state codes
	localparam logic [2:0] COMM_RX_WAIT = 3'h5;
	localparam logic [2:0] COMM_WAIT_DATA = 3'h6;
	localparam logic [2:0] COMM_RECEIVING = 3'h7;
	localparam logic [2:0] COMM_RESET = 3'h0;

	// ==========================================================
	// frame length limits
	localparam int MIN_FRAME_BITS = 4;
	localparam int MIN_EMD_BYTES = 3;
	localparam int BITS_PER_BYTE = 8;
	localparam logic [6:0] COLL_POS_RESET = 7'h00;

endpackage : ierx_pkg

`default_nettype wire

// >>> rtl/ierx_sticky_flag.sv
// one sticky error flag with set and clear strobes
// set and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module ierx_sticky_flag
	import ierx_pkg::*;
#(
	parameter logic RESET_VALUE = 1'b0
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic set,
	input wire logic clear,
	output logic flag
);

	logic flag_reg;
	logic flag_next;

	// ==========================================================
	// set wins over a clear in the same cycle
	always_comb
	begin
		flag_next = flag_reg;
		if (set)
		begin
			flag_next = 1'b1;
		end
		else if (clear)
		begin
			flag_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			flag_reg <= RESET_VALUE;
		end
		else
		begin
			flag_reg <= flag_next;
		end
	end

	assign flag = flag_reg;

endmodule : ierx_sticky_flag

`default_nettype wire

// >>> rtl/ierx_frame_check.sv
// counts data bits of a received frame and judges its length
// strobes come from the receive decoder on the same clock
`timescale 1ns/1ps
`default_nettype none

module ierx_frame_check
	import ierx_pkg::*;
#(
	parameter int CNT_W = 5
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic sof_valid,
	input wire logic data_bit,
	input wire logic frame_end,
	input wire logic emd_suppress,
	output logic short_frame,
	output logic frame_discard,
	output logic frame_accept
);

	typedef enum logic [1:0]
	{
		FC_IDLE = 2'b01,
		FC_FRAME = 2'b10
	} ierx_fc_state_e;

	localparam logic [CNT_W-1:0] BIT_LIMIT =
		CNT_W'(MIN_FRAME_BITS);
	localparam logic [CNT_W-1:0] EMD_LIMIT =
		CNT_W'(MIN_EMD_BYTES * BITS_PER_BYTE);

	ierx_fc_state_e state_reg;
	ierx_fc_state_e state_next;
	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic short_reg;
	logic short_next;
	logic discard_reg;
	logic discard_next;
	logic accept_reg;
	logic accept_next;

	// ==========================================================
	// length judgement at frame end
	always_comb
	begin
		state_next = state_reg;
		count_next = count_reg;
		short_next = 1'b0;
		discard_next = 1'b0;
		accept_next = 1'b0;
		unique case (state_reg)
			FC_IDLE:
			begin
				if (sof_valid)
				begin
					state_next = FC_FRAME;
					count_next = '0;
				end
			end
			FC_FRAME:
			begin
				if (frame_end)
				begin
					state_next = FC_IDLE;
					if (count_reg < BIT_LIMIT)
					begin
						short_next = 1'b1;
						discard_next = 1'b1;
					end
					else if (emd_suppress && count_reg < EMD_LIMIT)
					begin
						discard_next = 1'b1;
					end
					else
					begin
						accept_next = 1'b1;
					end
				end
				else if (data_bit && count_reg != EMD_LIMIT)
				begin
					count_next = count_reg + CNT_W'(1);
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= FC_IDLE;
			count_reg <= '0;
			short_reg <= 1'b0;
			discard_reg <= 1'b0;
			accept_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			count_reg <= count_next;
			short_reg <= short_next;
			discard_reg <= discard_next;
			accept_reg <= accept_next;
		end
	end

	assign short_frame = short_reg;
	assign frame_discard = discard_reg;
	assign frame_accept = accept_reg;

endmodule : ierx_frame_check

`default_nettype wire

// >>> tb/ierx_monitor.sv
// checker for pin, global flag and error flag outputs
// bound into ierx_top, sees its ports only
`timescale 1ns/1ps
`default_nettype none

module ierx_monitor
	import ierx_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic card_detect_request,
	input wire logic [4:0] timer_request,
	input wire logic other_enabled_request,
	input wire logic global_interrupt_flag,
	input wire logic irq_pin_out,
	input wire logic irq_pin_oe,
	input wire logic error_interrupt_request,
	input wire logic [7:0] error_flags,
	input wire logic fifo_write,
	input wire logic fifo_full,
	input wire logic fifo_write_accept,
	input wire logic collision_event,
	input wire logic collision_in_eof
);
	// ====================
	// enable register shadow
	logic [7:0] en_reg;
	logic req_m;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			en_reg <= IRQ_EN_RESET;
		end
		else if (reg_wr && reg_addr == IRQ_EN_OFFSET)
		begin
			en_reg <= reg_wdata;
		end
	end

	assign req_m = |(timer_request & en_reg[4:0])
		| (card_detect_request & en_reg[5]) | other_enabled_request;

	// ====================
	// properties
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_full_wr;
		fifo_write && fifo_full;
	endsequence
	sequence s_od;
		!en_reg[EN_DRIVE_BIT] ##1 !en_reg[EN_DRIVE_BIT];
	endsequence
	sequence s_pp;
		en_reg[EN_DRIVE_BIT] ##1 en_reg[EN_DRIVE_BIT];
	endsequence

	property p_glb;
		$past(rst_n) |-> global_interrupt_flag == $past(req_m);
	endproperty
	a_glb: assert property (p_glb)
		else $error("global flag does not follow enabled requests");
	property p_od;
		s_od |-> !irq_pin_out;
	endproperty
	a_od: assert property (p_od)
		else $error("open-drain pin driven high");
	property p_pp;
		s_pp |-> irq_pin_oe;
	endproperty
	a_pp: assert property (p_pp)
		else $error("push-pull pin not driven");
	property p_off;
		!en_reg[EN_PIN_BIT] [*3] |-> !irq_pin_out &&
			irq_pin_oe == $past(en_reg[EN_DRIVE_BIT]);
	endproperty
	a_off: assert property (p_off)
		else $error("pin active while pin enable is low");
	property p_eirq;
		error_interrupt_request ==
			|(error_flags & ~$past(error_flags) & ERR_IRQ_MASK);
	endproperty
	a_eirq: assert property (p_eirq)
		else $error("error request does not match new flags");
	property p_ovl;
		s_full_wr |=> error_flags[ERR_OVERFLOW_BIT] && !fifo_write_accept;
	endproperty
	a_ovl: assert property (p_ovl)
		else $error("full write did not set overflow");
	property p_drop;
		fifo_write && error_flags[ERR_OVERFLOW_BIT] |=> !fifo_write_accept;
	endproperty
	a_drop: assert property (p_drop)
		else $error("write accepted after overflow");
	property p_coll;
		collision_event && !collision_in_eof |=> error_flags[ERR_COLL_BIT];
	endproperty
	a_coll: assert property (p_coll)
		else $error("collision flag not set");
	property p_eof;
		collision_event && collision_in_eof && !error_flags[ERR_COLL_BIT]
			|=> !error_flags[ERR_COLL_BIT];
	endproperty
	a_eof: assert property (p_eof)
		else $error("end-of-frame collision set flag");
endmodule : ierx_monitor

bind ierx_top ierx_monitor u_ierx_monitor (.ref_clk, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .card_detect_request, .timer_request,
	.other_enabled_request, .global_interrupt_flag, .irq_pin_out,
	.irq_pin_oe, .error_interrupt_request, .error_flags, .fifo_write,
	.fifo_full, .fifo_write_accept, .collision_event, .collision_in_eof);

`default_nettype wire

// >>> tb/ierx_host.sv
// host model: register strobes and interrupt pin watch
// pin resolved here with a pull-up for open-drain use
`timescale 1ns/1ps
`default_nettype none

module ierx_host
(
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic irq_pin_out,
	input wire logic irq_pin_oe,
	output logic pin_level
);
	assign pin_level = irq_pin_oe ? irq_pin_out : 1'b1;

	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// released lines show the inverse of the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : ierx_host

`default_nettype wire

// >>> tb/tb_ierx_top.sv
// testbench for ierx_top with a host model on the register port
// event strobes are one-cycle pulses from the ev vector
`timescale 1ns/1ps
`default_nettype none

module tb_ierx_top
	import ierx_pkg::*;
;
	logic clk, rst_n, card, oth, ff, fe, multi, eof, cia;
	logic crc, auth, trx, emd;
	logic [4:0] tmr;
	logic [2:0] st;
	logic [6:0] cpos;
	logic [17:0] ev;
	logic [7:0] ra, wd, rdat, ef, cpr;
	logic wr, rdn, gif, po, poe, pin, eirq, acc, rxe, fd, rde, rbo;
	int err_total, total_checks, cyc;

	ierx_host u_ierx_host (.clk(clk), .reg_addr(ra), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rdn), .reg_rdata(rdat), .irq_pin_out(po),
		.irq_pin_oe(poe), .pin_level(pin));
	ierx_top u_ierx_top (.ref_clk(clk), .rst_n(rst_n), .reg_addr(ra),
		.reg_wdata(wd), .reg_wr(wr), .reg_rd(rdn), .reg_rdata(rdat),
		.card_detect_request(card), .timer_request(tmr),
		.other_enabled_request(oth), .global_interrupt_flag(gif),
		.irq_pin_in(pin), .irq_pin_out(po), .irq_pin_oe(poe),
		.error_interrupt_request(eirq), .error_flags(ef),
		.eeprom_cmd_start(ev[10]), .eeprom_cmd_error(ev[1]),
		.cl_command_start(ev[9]), .multi_frame_receive(multi),
		.error_flags_stored(ev[17]), .comm_state(st),
		.transceive_active(trx), .receive_start(ev[8]),
		.crc_tx_active(crc), .auth_active(auth), .fifo_write(ev[12]),
		.fifo_full(ff), .fifo_flush(ev[13]), .fifo_write_accept(acc),
		.tx_required(ev[0]), .fifo_empty(fe), .sof_valid(ev[14]),
		.data_bit(ev[15]), .frame_end(ev[16]), .emd_suppress(emd),
		.receive_end_interrupt(rxe), .frame_discard(fd),
		.receive_decoder_enable(rde), .collision_event(ev[7]),
		.collision_in_eof(eof), .collision_pos(cpos),
		.collision_as_integrity_control(cia),
		.collision_position_register(cpr), .stop_bit_error(ev[2]),
		.sof_error(ev[3]), .byte_count_error(ev[4]),
		.parity_error(ev[5]), .crc_error(ev[6]),
		.rx_byte_write(ev[11]), .rx_byte_write_out(rbo));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ====================
	// shared tasks
	task automatic chk(input string n, input logic [7:0] s,
		input logic [7:0] e);
		total_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk

	task automatic pulse(input logic [17:0] m);
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= '0;
		#1;
	endtask : pulse

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wt

	task automatic results;
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : results

	// ====================
	// scenarios
	task automatic t_regs;
		logic [7:0] d;
		u_ierx_host.rd(IRQ_EN_OFFSET, d);
		chk("en rst", d, IRQ_EN_RESET);
		u_ierx_host.wr(ERR_OFFSET, 8'hFF);
		u_ierx_host.rd(ERR_OFFSET, d);
		chk("err ro", d, ERR_RESET);
		u_ierx_host.wr(8'h3C, 8'hFF);
		u_ierx_host.rd(8'h3C, d);
		chk("unmapped", d, UNMAPPED_RDATA);
		u_ierx_host.wr(IRQ_EN_OFFSET, 8'hA5);
		u_ierx_host.rd(IRQ_EN_OFFSET, d);
		chk("en rw", d, 8'hA5);
	endtask : t_regs

	task automatic t_irq;
		for (int i = 0; i < 6; i++)
		begin
			{card, tmr} <= 6'h01 << i;
			u_ierx_host.wr(IRQ_EN_OFFSET, 8'hC0 | (8'h01 << i));
			wt(3);
			chk("glb on", gif, 1'b1);
			chk("pin pp", pin, 1'b1);
			u_ierx_host.wr(IRQ_EN_OFFSET, ~(8'h01 << i));
			wt(3);
			chk("glb off", gif, 1'b0);
		end
		{card, tmr, oth} <= 7'h01;
		u_ierx_host.wr(IRQ_EN_OFFSET, 8'h40);
		wt(3);
		chk("glb oth", gif, 1'b1);
		chk("pin od", pin, 1'b0);
		u_ierx_host.wr(IRQ_EN_OFFSET, 8'h00);
		wt(3);
		chk("pin off", pin, 1'b1);
		oth <= 1'b0;
	endtask : t_irq

	task automatic t_errs;
		logic [7:0] ex [8] = '{8'h08, 8'h80, 8'h02, 8'h02, 8'h02,
			8'h01, 8'h01, 8'h04};
		logic [7:0] d;
		fe <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			pulse(18'h1 << i);
			chk("flag", ef, ex[i]);
			chk("eirq", eirq, |(ex[i] & ERR_IRQ_MASK));
			pulse(18'h700);
			chk("clr", ef, 8'h00);
		end
		{cia, cpos} <= 8'hAA;
		pulse(18'h80);
		chk("coll integ", ef, 8'h05);
		chk("coll pos", cpr, 8'hAA);
		u_ierx_host.rd(ERR_OFFSET, d);
		chk("rd flags", d, 8'h05);
		chk("rd keep", ef, 8'h05);
		pulse(18'h700);
		eof <= 1'b1;
		pulse(18'h80);
		chk("eof coll", ef, 8'h00);
		pulse(18'h800);
		chk("byte out", rbo, 1'b1);
		pulse(18'h804);
		chk("byte drop", rbo, 1'b0);
		wt(1);
		chk("dec stop", rde, 1'b0);
		pulse(18'h700);
		for (int s = 5; s < 8; s++)
		begin
			st <= s[2:0];
			pulse(18'h1000);
			chk("wr err", ef, 8'h40);
			pulse(18'h700);
			chk("cmd clr", ef, 8'h00);
		end
		multi <= 1'b1;
		pulse(18'h1000);
		pulse(18'h200);
		chk("multi keep", ef, 8'h40);
		pulse(18'h20000);
		chk("stored clr", ef, 8'h00);
		st <= COMM_RESET;
		multi <= 1'b0;
		for (int k = 0; k < 2; k++)
		begin
			{crc, auth} <= 2'b01 << k;
			pulse(18'h1000);
			chk("busy wr", ef, 8'h40);
			pulse(18'h700);
		end
		{crc, auth} <= 2'b00;
		pulse(18'h1000);
		chk("idle wr", ef, 8'h00);
	endtask : t_errs

	task automatic t_trx;
		{trx, st} <= {1'b1, COMM_RX_WAIT};
		pulse(18'h20);
		chk("trx set", ef, 8'h01);
		st <= COMM_WAIT_DATA;
		wt(2);
		chk("trx clr", ef, 8'h00);
		pulse(18'h20);
		chk("trx hold", ef, 8'h01);
		{trx, st} <= {1'b0, COMM_RESET};
		pulse(18'h700);
	endtask : t_trx

	task automatic t_fifo;
		ff <= 1'b1;
		pulse(18'h1000);
		chk("ovl", ef, 8'h20);
		ff <= 1'b0;
		pulse(18'h1000);
		chk("ovl ign", acc, 1'b0);
		pulse(18'h2000);
		pulse(18'h1000);
		chk("acc", acc, 1'b1);
	endtask : t_fifo

	task automatic t_frame;
		for (int n = 3; n < 5; n++)
		begin
			pulse(18'h100);
			pulse(18'h4000);
			repeat (n) pulse(18'h8000);
			pulse(18'h10000);
			chk("discard", fd, n == 3);
			chk("rx end", rxe, n == 4);
			wt(1);
			chk("short", ef, (n == 3) ? 8'h10 : 8'h00);
			chk("dec on", rde, 1'b1);
		end
		emd <= 1'b1;
		pulse(18'h4000);
		repeat (4) pulse(18'h8000);
		pulse(18'h10000);
		chk("emd discard", fd, 1'b1);
		chk("emd rx end", rxe, 1'b0);
		wt(1);
		chk("emd short", ef, 8'h00);
		emd <= 1'b0;
	endtask : t_frame

	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_total++;
			results;
		end
	end

	initial
	begin
		{err_total, total_checks, cyc} = '0;
		{rst_n, card, oth, ff, fe, multi, eof, cia} = '0;
		{crc, auth, trx, emd} = '0;
		{tmr, st, cpos, ev} = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_irq;
		t_errs;
		t_trx;
		t_fifo;
		t_frame;
		results;
	end
endmodule : tb_ierx_top

`default_nettype wire
